// >>> design/bwpc_top.sv
// Function
// RL1: Update spacing equals interval count times one timebase period.
// RL2: Timebase codes 1,2,3 give 48, 44.1 and 32 kHz; the code also maps codes 0 and 7 to the code 1 timebase.
// RL3: Timebase codes 4,5,6 give 24, 22.05 and 16 kHz.
// RL4: Host programs interval one so update rate equals timebase; the testbench also programs interval two.
// RL5: Rate change mode zero switches rate at once, even mid-cycle.
// RL6: Rate change mode one while running waits for cycle end.
// RL7: Deferred change while idle applies on continue or ownerless begin.
// RL8: Rate change becomes default; begin reloads the buffer's own rate.
// RL9: Halt mode zero stops at once; mode one after the cycle.
// RL10: Continue resumes from the exact halted sample position.
// RL11: Continue after halt while waiting returns to trigger wait.
// RL12: Continue after halt while running restarts output at once.
// RL13: Release ends playback and frees the assigned DMA channels.
// RL14: Channel select 0, 1 single channel; 2 both from interleaved words.
// RL15: Host always gives channel group zero.
// RL16: Host picks buffer one and begin mode zero.
// RL17: Interval and timebase in effect are readable.
// RL18: Trigger modes: none, first falling edge, falling edge each cycle.
// RL19: Status 0 running, 1 done, 2 halted, 3 stale-data halt; the code never sets status 3.
// RL20: Outside running, outputs hold and read pointer stays.
`timescale 1ns/1ps
`default_nettype none
module bwpc_top #(
  parameter logic [15:0] P_TB1_CYC = 16'(bwpc_pkg::TB1_CYC),
  parameter logic [15:0] P_TB2_CYC = 16'(bwpc_pkg::TB2_CYC),
  parameter logic [15:0] P_TB3_CYC = 16'(bwpc_pkg::TB3_CYC),
  parameter logic [15:0] P_TB4_CYC = 16'(bwpc_pkg::TB4_CYC),
  parameter logic [15:0] P_TB5_CYC = 16'(bwpc_pkg::TB5_CYC),
  parameter logic [15:0] P_TB6_CYC = 16'(bwpc_pkg::TB6_CYC)
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic [7:0]  i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output var  logic        o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output var  logic        o_s_axi_wready,
  output var  logic [1:0]  o_s_axi_bresp,
  output var  logic        o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [7:0]  i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output var  logic        o_s_axi_arready,
  output var  logic [31:0] o_s_axi_rdata,
  output var  logic [1:0]  o_s_axi_rresp,
  output var  logic        o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  input  wire logic        i_external_trigger_n,
  output var  logic [15:0] o_dac0,
  output var  logic [15:0] o_dac1,
  output var  logic        o_update,
  output var  logic        o_dma_release
);
  ////////////////////////////////////////////////////////////////////////////
  bwpc_pkg::bwpc_state_t state_reg;
  bwpc_pkg::bwpc_cmd_t   cmd_reg;
  bwpc_pkg::bwpc_rate_t  rate_reg, bufrate_reg, dflt_reg, eff_reg, pend_reg;
  logic        cmd_vld_reg, own_rate_reg, pend_vld_reg, rate_ld_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic        aw_have_reg, w_have_reg;
  logic [4:0]  len_reg;
  logic [7:0]  cycles_reg, cyc_cnt_reg;
  logic [1:0]  trig_reg, chan_reg, status_reg;
  logic [3:0]  pos_reg;
  logic        stop_pend_reg, was_wait_reg;
  logic [15:0] pre_cnt_reg, ivl_cnt_reg;
  logic        trig_s1_reg, trig_s2_reg, trig_s3_reg;
  logic [31:0] mem [bwpc_pkg::BUF_DEPTH];
  logic [15:0] tb_cyc, ivl_last;
  logic        wr_fire, tick, wrap, fall, rate_now, rate_defer;
  logic [3:0]  last_pos;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus, one write and one read at a time
  assign wr_fire = aw_have_reg && w_have_reg && !o_s_axi_bvalid;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      aw_have_reg     <= 1'b0;
      w_have_reg      <= 1'b0;
      awaddr_reg      <= 8'h00;
      wdata_reg       <= 32'h0000_0000;
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready  <= 1'b0;
      o_s_axi_bvalid  <= 1'b0;
    end else begin
      o_s_axi_awready <= !aw_have_reg && !(o_s_axi_awready && i_s_axi_awvalid);
      o_s_axi_wready  <= !w_have_reg && !(o_s_axi_wready && i_s_axi_wvalid);
      if (o_s_axi_awready && i_s_axi_awvalid) begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= i_s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_reg <= 1'b0;
      end
      if (o_s_axi_wready && i_s_axi_wvalid) begin
        w_have_reg <= 1'b1;
        wdata_reg  <= i_s_axi_wdata;
      end else if (wr_fire) begin
        w_have_reg <= 1'b0;
      end
      if (wr_fire) begin
        o_s_axi_bvalid <= 1'b1;
      end else if (i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign o_s_axi_bresp = 2'h0;

  // Byte strobes ignored: registers hold whole command words
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cmd_vld_reg  <= 1'b0;
      cmd_reg      <= '0;
      rate_reg     <= bwpc_pkg::RATE_RST;
      bufrate_reg  <= bwpc_pkg::RATE_RST;
      own_rate_reg <= 1'b0;
      len_reg      <= 5'h10;
      cycles_reg   <= 8'h00;
      trig_reg     <= bwpc_pkg::TRIG_NONE;
    end else begin
      cmd_vld_reg <= wr_fire && awaddr_reg == bwpc_pkg::OFF_CMD;
      if (wr_fire) begin
        case (awaddr_reg)
          bwpc_pkg::OFF_CMD: cmd_reg <= bwpc_pkg::bwpc_cmd_t'(wdata_reg[5:0]);
          bwpc_pkg::OFF_RATE: rate_reg <= bwpc_pkg::bwpc_rate_t'(wdata_reg[18:0]);
          bwpc_pkg::OFF_BUFCFG: begin
            len_reg    <= wdata_reg[bwpc_pkg::CFG_LEN_LSB +: 5];
            cycles_reg <= wdata_reg[bwpc_pkg::CFG_CYC_LSB +: 8];
            trig_reg   <= wdata_reg[bwpc_pkg::CFG_TRIG_LSB +: 2];
          end
          bwpc_pkg::OFF_BUFRATE: begin
            bufrate_reg  <= bwpc_pkg::bwpc_rate_t'(wdata_reg[18:0]);
            own_rate_reg <= wdata_reg[bwpc_pkg::OWN_RATE_BIT];
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (wr_fire && awaddr_reg[7:6] == bwpc_pkg::OFF_BUF[7:6]) begin
      mem[awaddr_reg[5:2]] <= wdata_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= 32'h0000_0000;
    end else begin
      o_s_axi_arready <= !o_s_axi_rvalid && !(o_s_axi_arready && i_s_axi_arvalid);
      if (o_s_axi_arready && i_s_axi_arvalid) begin
        o_s_axi_rvalid <= 1'b1;
        case (i_s_axi_araddr)
          bwpc_pkg::OFF_RATE: o_s_axi_rdata <= {13'h0000, rate_reg};
          bwpc_pkg::OFF_BUFCFG: o_s_axi_rdata <= {14'h0000, trig_reg, cycles_reg, 3'h0, len_reg};
          bwpc_pkg::OFF_BUFRATE: o_s_axi_rdata <= {own_rate_reg, 12'h000, bufrate_reg};
          bwpc_pkg::OFF_STATUS:
            o_s_axi_rdata <= {8'h00, cyc_cnt_reg, 4'h0, pos_reg, 2'h0, chan_reg, 2'h0, status_reg};
          bwpc_pkg::OFF_EFF: o_s_axi_rdata <= {13'h0000, eff_reg}; // RL17
          default: o_s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
      end
    end
  end
  assign o_s_axi_rresp = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Timebase and update tick
  always_comb begin
    case (eff_reg.tb)
      3'h2: tb_cyc = P_TB2_CYC; // RL2
      3'h3: tb_cyc = P_TB3_CYC; // RL2
      3'h4: tb_cyc = P_TB4_CYC; // RL3
      3'h5: tb_cyc = P_TB5_CYC; // RL3
      3'h6: tb_cyc = P_TB6_CYC; // RL3
      default: tb_cyc = P_TB1_CYC; // RL2
    endcase
  end

  // Interval zero behaves as one rather than stalling forever
  assign ivl_last = (eff_reg.interval == 16'h0000) ? 16'h0000 : eff_reg.interval - 16'h0001;
  assign tick     = state_reg == bwpc_pkg::S_RUN && !rate_ld_reg && pre_cnt_reg == tb_cyc - 16'h0001
                    && ivl_cnt_reg == ivl_last; // RL1
  assign last_pos = len_reg == 5'h00 ? 4'h0 : 4'(len_reg - 5'h01);
  assign wrap     = tick && pos_reg == last_pos;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b || state_reg != bwpc_pkg::S_RUN || rate_ld_reg) begin
      pre_cnt_reg <= 16'h0000;
      ivl_cnt_reg <= 16'h0000;
    end else if (pre_cnt_reg == tb_cyc - 16'h0001) begin // RL1
      pre_cnt_reg <= 16'h0000;
      ivl_cnt_reg <= (ivl_cnt_reg == ivl_last) ? 16'h0000 : ivl_cnt_reg + 16'h0001;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 16'h0001;
    end
  end

  // Pin crosses two flops before the edge detector
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      trig_s1_reg <= 1'b1;
      trig_s2_reg <= 1'b1;
      trig_s3_reg <= 1'b1;
    end else begin
      trig_s1_reg <= i_external_trigger_n;
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
    end
  end
  assign fall = trig_s3_reg && !trig_s2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Rate selection
  assign rate_now   = cmd_vld_reg && cmd_reg.op == bwpc_pkg::OP_RATE && !cmd_reg.mode;
  assign rate_defer = cmd_vld_reg && cmd_reg.op == bwpc_pkg::OP_RATE && cmd_reg.mode;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      dflt_reg     <= bwpc_pkg::RATE_RST;
      eff_reg      <= bwpc_pkg::RATE_RST;
      pend_reg     <= bwpc_pkg::RATE_RST;
      pend_vld_reg <= 1'b0;
      rate_ld_reg  <= 1'b0;
    end else begin
      rate_ld_reg <= 1'b0;
      if (cmd_vld_reg && cmd_reg.op == bwpc_pkg::OP_BEGIN) begin
        eff_reg      <= own_rate_reg ? bufrate_reg : dflt_reg; // RL8 RL7
        pend_vld_reg <= 1'b0; // RL8
        rate_ld_reg  <= 1'b1;
      end else if (rate_now) begin
        dflt_reg     <= rate_reg; // RL8
        eff_reg      <= rate_reg; // RL5
        pend_vld_reg <= 1'b0;
        rate_ld_reg  <= 1'b1;
      end else if (rate_defer) begin
        dflt_reg     <= rate_reg; // RL8
        pend_reg     <= rate_reg; // RL6
        pend_vld_reg <= 1'b1;
      end else if (pend_vld_reg && (wrap || (cmd_vld_reg && cmd_reg.op == bwpc_pkg::OP_CONTINUE
                                             && state_reg == bwpc_pkg::S_HALT))) begin
        eff_reg      <= pend_reg; // RL6 RL7
        pend_vld_reg <= 1'b0;
        rate_ld_reg  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Playback sequencer
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_reg     <= bwpc_pkg::S_IDLE;
      status_reg    <= bwpc_pkg::ST_DONE;
      pos_reg       <= 4'h0;
      cyc_cnt_reg   <= 8'h00;
      chan_reg      <= bwpc_pkg::CH_ZERO;
      stop_pend_reg <= 1'b0;
      was_wait_reg  <= 1'b0;
      o_dma_release <= 1'b0;
    end else begin
      o_dma_release <= 1'b0;
      if (cmd_vld_reg && cmd_reg.op == bwpc_pkg::OP_RELEASE) begin
        state_reg     <= bwpc_pkg::S_IDLE; // RL13
        status_reg    <= bwpc_pkg::ST_DONE;
        stop_pend_reg <= 1'b0;
        o_dma_release <= 1'b1; // RL13
      end else if (cmd_vld_reg && cmd_reg.op == bwpc_pkg::OP_BEGIN) begin
        pos_reg       <= 4'h0;
        cyc_cnt_reg   <= 8'h00;
        chan_reg      <= cmd_reg.chan; // RL14
        stop_pend_reg <= 1'b0;
        status_reg    <= bwpc_pkg::ST_RUN;
        state_reg     <= trig_reg == bwpc_pkg::TRIG_NONE ? bwpc_pkg::S_RUN : bwpc_pkg::S_WAIT; // RL18
      end else if (cmd_vld_reg && cmd_reg.op == bwpc_pkg::OP_HALT
                   && (state_reg == bwpc_pkg::S_RUN || state_reg == bwpc_pkg::S_WAIT)) begin
        // A waiting device has no cycle in flight, so it halts at once
        if (!cmd_reg.mode || state_reg == bwpc_pkg::S_WAIT) begin
          state_reg    <= bwpc_pkg::S_HALT; // RL9
          status_reg   <= bwpc_pkg::ST_HALT; // RL19
          was_wait_reg <= state_reg == bwpc_pkg::S_WAIT;
        end else begin
          stop_pend_reg <= 1'b1; // RL9
        end
      end else if (cmd_vld_reg && cmd_reg.op == bwpc_pkg::OP_CONTINUE && state_reg == bwpc_pkg::S_HALT) begin
        status_reg <= bwpc_pkg::ST_RUN;
        state_reg  <= was_wait_reg ? bwpc_pkg::S_WAIT : bwpc_pkg::S_RUN; // RL10 RL11 RL12
      end else begin
        case (state_reg)
          bwpc_pkg::S_WAIT: if (fall) state_reg <= bwpc_pkg::S_RUN; // RL18
          bwpc_pkg::S_RUN: if (tick) begin
            pos_reg <= wrap ? 4'h0 : pos_reg + 4'h1;
            if (wrap) begin
              cyc_cnt_reg <= cyc_cnt_reg + 8'h01;
              if (cycles_reg != 8'h00 && cyc_cnt_reg + 8'h01 == cycles_reg) begin
                state_reg  <= bwpc_pkg::S_IDLE;
                status_reg <= bwpc_pkg::ST_DONE; // RL19
              end else if (stop_pend_reg) begin
                state_reg     <= bwpc_pkg::S_HALT; // RL9
                status_reg    <= bwpc_pkg::ST_HALT;
                stop_pend_reg <= 1'b0;
                was_wait_reg  <= 1'b0;
              end else if (trig_reg == bwpc_pkg::TRIG_EVERY) begin
                state_reg <= bwpc_pkg::S_WAIT; // RL18
              end
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Outputs only move on a running tick; idle and halt hold the last sample
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_dac0   <= 16'h0000;
      o_dac1   <= 16'h0000;
      o_update <= 1'b0;
    end else begin
      o_update <= tick;
      if (tick) begin // RL20
        if (chan_reg == bwpc_pkg::CH_ZERO || chan_reg == bwpc_pkg::CH_BOTH) o_dac0 <= mem[pos_reg][15:0]; // RL14
        if (chan_reg == bwpc_pkg::CH_ONE) o_dac1 <= mem[pos_reg][15:0]; // RL14
        if (chan_reg == bwpc_pkg::CH_BOTH) o_dac1 <= mem[pos_reg][31:16]; // RL14
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] gap_reg;
  logic        gap_ok_reg;
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || state_reg != bwpc_pkg::S_RUN || rate_ld_reg) begin
      gap_reg    <= 32'h0000_0000;
      gap_ok_reg <= 1'b0;
    end else begin
      gap_reg    <= tick ? 32'h0000_0000 : gap_reg + 32'h0000_0001;
      gap_ok_reg <= gap_ok_reg || tick;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_cmd(logic [2:0] op);
    cmd_vld_reg && cmd_reg.op == op;
  endsequence
  sequence s_halt_then_run;
    state_reg == bwpc_pkg::S_HALT ##1 state_reg == bwpc_pkg::S_RUN;
  endsequence

  AST_RL1_SPACING: assert property (tick && gap_ok_reg && eff_reg.interval != 16'h0000 |->  // RL1
    gap_reg + 32'h1 == 32'(tb_cyc) * 32'(eff_reg.interval)) else $error("update spacing wrong");
  AST_RL2_TB3: assert property (eff_reg.tb == 3'h3 |-> tb_cyc == P_TB3_CYC) else $error("code 3 map"); // RL2
  AST_RL3_TB6: assert property (eff_reg.tb == 3'h6 |-> tb_cyc == P_TB6_CYC) else $error("code 6 map"); // RL3
  AST_RL5_NOW: assert property (s_cmd(bwpc_pkg::OP_RATE) and !cmd_reg.mode |=> // RL5
    eff_reg == $past(rate_reg) ##1 !tick) else $error("immediate rate not applied");
  AST_RL6_HOLD: assert property (s_cmd(bwpc_pkg::OP_RATE) and cmd_reg.mode and !wrap |=> // RL6
    $stable(eff_reg)) else $error("deferred rate applied early");
  AST_RL9_NOW: assert property (s_cmd(bwpc_pkg::OP_HALT) and !cmd_reg.mode and state_reg == bwpc_pkg::S_RUN
    |=> state_reg == bwpc_pkg::S_HALT && status_reg == bwpc_pkg::ST_HALT) else $error("halt late"); // RL9
  AST_RL10_POS: assert property (s_halt_then_run |-> pos_reg == $past(pos_reg)) else $error("position lost"); // RL10
  AST_RL11_WAIT: assert property (s_cmd(bwpc_pkg::OP_CONTINUE) and state_reg == bwpc_pkg::S_HALT // RL11
    and was_wait_reg |=> state_reg == bwpc_pkg::S_WAIT) else $error("trigger wait not restored");
  AST_RL13_REL: assert property (s_cmd(bwpc_pkg::OP_RELEASE) |=> // RL13
    state_reg == bwpc_pkg::S_IDLE && o_dma_release ##1 !o_dma_release) else $error("release failed");
  AST_RL18_EDGE: assert property (state_reg == bwpc_pkg::S_WAIT && fall && !cmd_vld_reg |=> // RL18
    state_reg == bwpc_pkg::S_RUN) else $error("trigger edge missed");
  AST_RL20_HOLD: assert property (state_reg != bwpc_pkg::S_RUN |=> $stable(o_dac0) && $stable(o_dac1)) // RL20
    else $error("output moved while not running");
endmodule // bwpc_top
`default_nettype wire

// >>> design/bwpc_pkg.sv
`default_nettype none
package bwpc_pkg;
  localparam int unsigned CLK_HZ  = 100_000_000;
  localparam int unsigned TB1_HZ  = 48_000;
  localparam int unsigned TB2_HZ  = 44_100;
  localparam int unsigned TB3_HZ  = 32_000;
  localparam int unsigned TB4_HZ  = 24_000;
  localparam int unsigned TB5_HZ  = 22_050;
  localparam int unsigned TB6_HZ  = 16_000;
  localparam int unsigned TB1_CYC = CLK_HZ / TB1_HZ;
  localparam int unsigned TB2_CYC = CLK_HZ / TB2_HZ;
  localparam int unsigned TB3_CYC = CLK_HZ / TB3_HZ;
  localparam int unsigned TB4_CYC = CLK_HZ / TB4_HZ;
  localparam int unsigned TB5_CYC = CLK_HZ / TB5_HZ;
  localparam int unsigned TB6_CYC = CLK_HZ / TB6_HZ;

  localparam logic [7:0] OFF_CMD     = 8'h00;
  localparam logic [7:0] OFF_RATE    = 8'h04;
  localparam logic [7:0] OFF_BUFCFG  = 8'h08;
  localparam logic [7:0] OFF_BUFRATE = 8'h0c;
  localparam logic [7:0] OFF_STATUS  = 8'h10;
  localparam logic [7:0] OFF_EFF     = 8'h14;
  localparam logic [7:0] OFF_BUF     = 8'h40;
  localparam int unsigned BUF_DEPTH  = 16;

  localparam int unsigned CFG_LEN_LSB   = 0;
  localparam int unsigned CFG_CYC_LSB   = 8;
  localparam int unsigned CFG_TRIG_LSB  = 16;
  localparam int unsigned OWN_RATE_BIT  = 31;

  localparam logic [2:0] OP_BEGIN    = 3'h1;
  localparam logic [2:0] OP_HALT     = 3'h2;
  localparam logic [2:0] OP_CONTINUE = 3'h3;
  localparam logic [2:0] OP_RATE     = 3'h4;
  localparam logic [2:0] OP_RELEASE  = 3'h5;

  localparam logic [1:0] ST_RUN   = 2'h0;
  localparam logic [1:0] ST_DONE  = 2'h1;
  localparam logic [1:0] ST_HALT  = 2'h2;
  localparam logic [1:0] ST_STALE = 2'h3;

  localparam logic [1:0] TRIG_NONE  = 2'h0;
  localparam logic [1:0] TRIG_FIRST = 2'h1;
  localparam logic [1:0] TRIG_EVERY = 2'h2;

  localparam logic [1:0] CH_ZERO = 2'h0;
  localparam logic [1:0] CH_ONE  = 2'h1;
  localparam logic [1:0] CH_BOTH = 2'h2;

  typedef struct packed {
    logic [1:0] chan;
    logic       mode;
    logic [2:0] op;
  } bwpc_cmd_t;

  typedef struct packed {
    logic [2:0]  tb;
    logic [15:0] interval;
  } bwpc_rate_t;

  localparam bwpc_rate_t RATE_RST = '{tb: 3'h1, interval: 16'h0001};

  typedef enum {S_IDLE, S_WAIT, S_RUN, S_HALT} bwpc_state_t;
endpackage
`default_nettype wire

// >>> bench/bwpc_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host driver model: one write and one read at a time
module bwpc_host (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_data,
  output var  logic        o_busy,
  output var  logic        o_rdone,
  output var  logic [31:0] o_rdata,
  output var  logic [7:0]  o_awaddr,
  output var  logic        o_awvalid,
  input  wire logic        i_awready,
  output var  logic [31:0] o_wdata,
  output var  logic        o_wvalid,
  input  wire logic        i_wready,
  input  wire logic        i_bvalid,
  output var  logic        o_bready,
  output var  logic [7:0]  o_araddr,
  output var  logic        o_arvalid,
  input  wire logic        i_arready,
  input  wire logic [31:0] i_rdata,
  input  wire logic        i_rvalid,
  output var  logic        o_rready
);
  initial {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready, o_awaddr, o_araddr, o_wdata} = '0;
  always_comb o_busy = o_awvalid | o_wvalid | o_bready | o_arvalid | o_rready;
  // Ready held from the start: the slave may answer at any edge
  always @(posedge i_clk) begin
    o_rdone <= 1'b0;
    if (!i_rst_b) begin
      {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} <= 5'h00;
      o_rdata <= 32'h0;
    end else begin
      if (i_req && i_we) begin
        {o_awaddr, o_wdata, o_awvalid, o_wvalid, o_bready} <= {i_addr, i_data, 3'h7};
      end
      if (i_req && !i_we) begin
        {o_araddr, o_arvalid, o_rready} <= {i_addr, 2'h3};
      end
      if (o_awvalid && i_awready) o_awvalid <= 1'b0;
      if (o_wvalid && i_wready) o_wvalid <= 1'b0;
      if (o_bready && i_bvalid) o_bready <= 1'b0;
      if (o_arvalid && i_arready) o_arvalid <= 1'b0;
      if (o_rready && i_rvalid) begin
        {o_rready, o_rdone, o_rdata} <= {2'h1, i_rdata};
      end
    end
  end
endmodule // bwpc_host
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int CYC [6] = '{20, 24, 28, 32, 36, 40};
  logic        i_clk, i_rst_b, req, we, trig_n, busy, rdone, upd, rel;
  logic        awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
  logic [7:0]  addr, awaddr, araddr;
  logic [31:0] data, rdata, wdata, s_rdata, d, hv;
  logic [1:0]  bresp, rresp;
  logic [15:0] dac0, dac1;
  logic [3:0]  p;
  logic [31:0] w [4];
  logic [31:0] exp_q [$];
  logic [31:0] msk_q [$];
  integer      seed, failures, num_checks, rel_cnt, tmo;
  bwpc_top #(.P_TB1_CYC(16'(CYC[0])), .P_TB2_CYC(16'(CYC[1])), .P_TB3_CYC(16'(CYC[2])),
    .P_TB4_CYC(16'(CYC[3])), .P_TB5_CYC(16'(CYC[4])), .P_TB6_CYC(16'(CYC[5]))) dut_u (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awv),
    .o_s_axi_awready(awr), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wrd), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv), .i_s_axi_bready(br),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(s_rdata),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rv), .i_s_axi_rready(rr), .i_external_trigger_n(trig_n),
    .o_dac0(dac0), .o_dac1(dac1), .o_update(upd), .o_dma_release(rel));
  bwpc_host host_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(req), .i_we(we), .i_addr(addr),
    .i_data(data), .o_busy(busy), .o_rdone(rdone), .o_rdata(rdata), .o_awaddr(awaddr),
    .o_awvalid(awv), .i_awready(awr), .o_wdata(wdata), .o_wvalid(wv), .i_wready(wrd),
    .i_bvalid(bv), .o_bready(br), .o_araddr(araddr), .o_arvalid(arv), .i_arready(arr),
    .i_rdata(s_rdata), .i_rvalid(rv), .o_rready(rr));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic xfer(input logic w_, input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk);
    {req, we, addr, data} <= {1'b1, w_, a, v};
    @(posedge i_clk);
    req <= 1'b0;
    @(negedge i_clk);
    while (busy !== 1'b0) @(negedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    xfer(1'b1, a, v);
  endtask
  // Mask zero: read only for its data, no compare
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    xfer(1'b0, a, 32'h0);
    d = rdata;
  endtask
  always @(negedge i_clk) begin
    if (rdone === 1'b1 && exp_q.size() > 0) begin
      if (msk_q[0] != 0) chk("read", exp_q[0], rdata & msk_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    if (rel === 1'b1) rel_cnt++;
  end
  always @(posedge i_clk) begin
    tmo++;
    if (tmo == 80000) begin
      failures++;
      results();
    end
  end
  task automatic wait_upd();
    int k;
    k = 0;
    while (upd !== 1'b1 && k < 3000) begin
      @(negedge i_clk);
      k++;
    end
  endtask
  // First two updates after a change are skipped; the interval from the second to the third is measured
  task automatic gap(input int e);
    int n;
    wait_upd();
    @(negedge i_clk);
    wait_upd();
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (upd !== 1'b1 && n < 3000);
    chk("gap", e, n);
  endtask
  task automatic cnt(input int c, input int e);
    int n;
    n = 0;
    repeat (c) begin
      @(negedge i_clk);
      if (upd === 1'b1) n++;
    end
    chk("updates", e, n);
  endtask
  task automatic pos(input logic [3:0] v);
    int k;
    k = 0;
    do begin
      rd(bwpc_pkg::OFF_STATUS, 32'h0, 32'h0);
      k++;
    end while (d[11:8] !== v && k < 100);
  endtask
  task automatic trg();
    @(posedge i_clk);
    trig_n <= 1'b0;
    repeat (5) @(posedge i_clk);
    trig_n <= 1'b1;
  endtask
  task automatic cmd(input logic [2:0] op, input logic m, input logic [1:0] ch = 2'h2);
    wr(bwpc_pkg::OFF_CMD, {26'h0, ch, m, op});
  endtask
  function automatic logic [31:0] hit(logic [1:0] ch);
    hit = 32'h0;
    for (int i = 0; i < 4; i++) begin
      if (ch == 2'h2 && {dac1, dac0} === w[i]) hit = 32'h1;
      if (ch == 2'h0 && dac0 === w[i][15:0]) hit = 32'h1;
      if (ch == 2'h1 && dac1 === w[i][15:0]) hit = 32'h1;
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {req, we, addr, data, trig_n, i_rst_b} = {2'h0, 8'h0, 32'h0, 2'h2};
    i_rst_b = 1'b0;
    {failures, num_checks, rel_cnt, tmo} = '0;
    seed = 32'hfd30;
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rd(bwpc_pkg::OFF_RATE, 32'h0001_0001, '1);
    rd(bwpc_pkg::OFF_EFF, 32'h0001_0001, '1);
    rd(bwpc_pkg::OFF_STATUS, 32'h1, 32'h3);
    rd(8'h30, 32'h0, '1);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      w[i] = $random(seed);
      wr(bwpc_pkg::OFF_BUF + 8'(4 * i), w[i]);
    end
    wr(bwpc_pkg::OFF_BUFCFG, 32'h4);
    wr(bwpc_pkg::OFF_BUFRATE, 32'h0);
    // Buffer one, group zero, begin mode zero are implied by the command word
    cmd(bwpc_pkg::OP_BEGIN, 1'b0);
    rd(bwpc_pkg::OFF_STATUS, 32'h0, 32'h3);
    for (int c = 1; c <= 6; c++) begin
      wr(bwpc_pkg::OFF_RATE, {13'h0, 3'(c), 16'h1});
      cmd(bwpc_pkg::OP_RATE, 1'b0);
      gap(CYC[c-1]);
      rd(bwpc_pkg::OFF_EFF, {13'h0, 3'(c), 16'h1}, '1);
    end
    chk("dac", 32'h1, hit(bwpc_pkg::CH_BOTH));
    wr(bwpc_pkg::OFF_RATE, 32'h0001_0002);
    cmd(bwpc_pkg::OP_RATE, 1'b0);
    gap(2 * CYC[0]);
    $display("test rates done");
    wr(bwpc_pkg::OFF_RATE, 32'h0006_0001);
    pos(4'h1);
    cmd(bwpc_pkg::OP_RATE, 1'b1);
    rd(bwpc_pkg::OFF_EFF, 32'h0001_0002, '1);
    repeat (200) @(negedge i_clk);
    rd(bwpc_pkg::OFF_EFF, 32'h0006_0001, '1);
    gap(CYC[5]);
    $display("test deferred rate done");
    cmd(bwpc_pkg::OP_HALT, 1'b0);
    rd(bwpc_pkg::OFF_STATUS, 32'h2, 32'h3);
    p = d[11:8];
    hv = {dac1, dac0};
    wr(bwpc_pkg::OFF_RATE, 32'h0002_0001);
    cmd(bwpc_pkg::OP_RATE, 1'b1);
    cnt(300, 0);
    chk("hold", hv, {dac1, dac0});
    rd(bwpc_pkg::OFF_STATUS, {20'h0, p, 8'h0}, 32'hf00);
    rd(bwpc_pkg::OFF_EFF, 32'h0006_0001, '1);
    cmd(bwpc_pkg::OP_CONTINUE, 1'b0);
    rd(bwpc_pkg::OFF_EFF, 32'h0002_0001, '1);
    wait_upd();
    rd(bwpc_pkg::OFF_STATUS, {20'h0, 2'h0, p[1:0] + 2'h1, 8'h0}, 32'hf03);
    pos(4'h1);
    cmd(bwpc_pkg::OP_HALT, 1'b1);
    rd(bwpc_pkg::OFF_STATUS, 32'h0, 32'h3);
    repeat (200) @(negedge i_clk);
    rd(bwpc_pkg::OFF_STATUS, 32'h2, 32'hf03);
    $display("test halt done");
    cmd(bwpc_pkg::OP_RELEASE, 1'b0);
    rd(bwpc_pkg::OFF_STATUS, 32'h1, 32'h3);
    chk("release", 32'h1, rel_cnt);
    cnt(100, 0);
    wr(bwpc_pkg::OFF_BUFRATE, 32'h8003_0001);
    cmd(bwpc_pkg::OP_BEGIN, 1'b0);
    rd(bwpc_pkg::OFF_EFF, 32'h0003_0001, '1);
    wr(bwpc_pkg::OFF_BUFRATE, 32'h0);
    for (int c = 0; c < 3; c++) begin
      cmd(bwpc_pkg::OP_RELEASE, 1'b0);
      cmd(bwpc_pkg::OP_BEGIN, 1'b0, 2'(c));
      rd(bwpc_pkg::OFF_EFF, 32'h0002_0001, '1);
      wait_upd();
      @(negedge i_clk);
      chk("dac", 32'h1, hit(2'(c)));
    end
    $display("test release and channels done");
    cmd(bwpc_pkg::OP_RELEASE, 1'b0);
    wr(bwpc_pkg::OFF_BUFCFG, 32'h0001_0004);
    cmd(bwpc_pkg::OP_BEGIN, 1'b0, 2'h0);
    cnt(300, 0);
    cmd(bwpc_pkg::OP_HALT, 1'b0, 2'h0);
    cmd(bwpc_pkg::OP_CONTINUE, 1'b0, 2'h0);
    cnt(300, 0);
    trg();
    gap(CYC[1]);
    cmd(bwpc_pkg::OP_RELEASE, 1'b0, 2'h0);
    wr(bwpc_pkg::OFF_BUFCFG, 32'h0002_0004);
    cmd(bwpc_pkg::OP_BEGIN, 1'b0, 2'h0);
    trg();
    cnt(400, 4);
    $display("test trigger done");
    results();
  end
endmodule // testbench
`default_nettype wire
